// file: dv/dbt_cpu_bfm.sv
// CPU-side model: one bus cycle per call, no quiet cycle between back-to-back calls
`timescale 1ns/100ps
`default_nettype none
module dbt_cpu_bfm (
    input  wire logic              mclk,
    output var  dbt_pkg::dbt_cpu_s  cpu,
    output var  dbt_pkg::dbt_exec_s exec_op,
    output var  dbt_pkg::dbt_cof_s  cof
);
    import dbt_pkg::*;
    localparam logic [15:0] IDLE_A = 16'h0100; // Clear of every compare
    // Quiet bus: no fetch, no flow change
    initial begin
        cpu = '{IDLE_A, 8'h5A, 8'hA5, 1'b1, 1'b0, 1'b0};
        exec_op = '0;
        cof = '0;
    end
    // Read data inverts the idle 5A, so every bus cycle reads A5
    task automatic bus(input logic [15:0] a, input logic f,
                       input dbt_cof_e k, input logic [15:0] d);
        cpu <= '{a, ~cpu.rdata, 8'hA5, 1'b1, f, 1'b0};
        exec_op <= '{f, a};
        cof <= '{k, a, d};
        @(posedge mclk);
        cpu <= '{IDLE_A, 8'h5A, 8'hA5, 1'b1, 1'b0, 1'b0};
        exec_op <= '0;
        cof <= '0;
        #1;
    endtask
    // Background debugger cycle: address shown, compares must stay blind
    task automatic debugger_cycle(input logic [15:0] a);
        cpu <= '{a, 8'h5A, 8'hA5, 1'b1, 1'b0, 1'b1};
        @(posedge mclk);
        cpu <= '{IDLE_A, 8'h5A, 8'hA5, 1'b1, 1'b0, 1'b0};
        #1;
    endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// Bench: breakpoints, trace capture and FIFO read-out
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dbt_pkg::*;
    logic         mclk = 1'b0;
    logic         rst_n = 1'b0;
    dbt_cpu_s     cpu;
    dbt_exec_s    exec_op;
    dbt_cof_s     cof;
    dbt_reg_req_s reg_req = '0;
    logic [7:0]   reg_rdata;
    logic         force_break;
    logic         tag_break;
    logic         armed_flag;
    int           error_cnt = 0;
    int           n_checks = 0;
    logic [15:0]  exp_q[$];
    dbt_cof_e     ks[10] = '{COF_COND, COF_ALWAYS, COF_INDIRECT, COF_NEVER,
        COF_IRQ, COF_RET_INT, COF_RET_SUB, COF_COND, COF_COND, COF_COND};
    // 40 MHz bus clock
    always #12.5 mclk = ~mclk;
    dbt_top u_dbt_top (.mclk(mclk), .rst_n(rst_n), .cpu(cpu),
        .exec_op(exec_op), .cof(cof), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .force_break(force_break),
        .tag_break(tag_break), .armed_flag(armed_flag));
    dbt_cpu_bfm u_dbt_cpu_bfm (.mclk(mclk), .cpu(cpu), .exec_op(exec_op),
        .cof(cof));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Strobe dropped on the edge, next one raised 1 ns later: no gap
    task automatic rq(input logic [3:0] a, input logic [7:0] d,
                      input logic w, input logic r);
        reg_req <= '{a, d, w, r};
        @(posedge mclk);
        reg_req <= '0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        rq(a, 8'h00, 1'b0, 1'b1);
        chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        rd(R_BDC_CTL, 8'h00);
        rd(4'hF, 8'h00);
        u_dbt_cpu_bfm.bus(16'h0000, 1'b1, COF_NONE, 16'h0000);
        chk("force_break", 16'h0, {15'h0, force_break});
        rq(R_BKPT_H, 8'h12, 1'b1, 1'b0);
        rq(R_BKPT_L, 8'h34, 1'b1, 1'b0);
        rq(R_BDC_CTL, 8'hC0, 1'b1, 1'b0);
        u_dbt_cpu_bfm.bus(16'h1234, 1'b0, COF_NONE, 16'h0000);
        chk("force_break", 16'h1, {15'h0, force_break});
        rq(R_BDC_CTL, 8'h80, 1'b1, 1'b0);
        u_dbt_cpu_bfm.bus(16'h1234, 1'b1, COF_NONE, 16'h0000);
        chk("tag_break", 16'h1, {15'h0, tag_break});
        chk("force_break", 16'h0, {15'h0, force_break});
        // Begin trace on comparator A at 0x0200
        rq(R_CMPA_H, 8'h02, 1'b1, 1'b0);
        rq(R_CMPA_L, 8'h00, 1'b1, 1'b0);
        rq(R_TRIG, 8'h40, 1'b1, 1'b0);
        rq(R_CTRL, 8'h80, 1'b1, 1'b0);
        chk("armed_flag", 16'h1, {15'h0, armed_flag});
        u_dbt_cpu_bfm.debugger_cycle(16'h0200);
        rd(R_STAT, 8'h20);
        u_dbt_cpu_bfm.bus(16'h0200, 1'b1, COF_COND, 16'h0000);
        u_dbt_cpu_bfm.bus(16'h0300, 1'b1, COF_COND, 16'h0000);
        u_dbt_cpu_bfm.bus(16'h0301, 1'b1, COF_IRQ, 16'h0999);
        for (int i = 0; i < 10; i++) begin
            u_dbt_cpu_bfm.bus(16'h0400 + 16'(i), 1'b1, ks[i],
                              16'h0800 + 16'(i));
            if (ks[i] == COF_COND)
                exp_q.push_back(16'h0400 + 16'(i));
            else if (ks[i] != COF_ALWAYS && ks[i] != COF_NEVER)
                exp_q.push_back(16'h0800 + 16'(i));
        end
        rd(R_STAT, 8'h88);
        chk("armed_flag", 16'h0, {15'h0, armed_flag});
        foreach (exp_q[i]) begin
            rd(R_FIFO_H, exp_q[i][15:8]);
            rd(R_FIFO_L, exp_q[i][7:0]);
        end
        // Idle low reads pushed the last fetch address behind the run
        rd(R_FIFO_H, 8'h04);
        rd(R_FIFO_L, 8'h09);
        // Early disarm after one stored word: contents sit one slot on
        rq(R_CTRL, 8'h80, 1'b1, 1'b0);
        u_dbt_cpu_bfm.bus(16'h0200, 1'b1, COF_COND, 16'h0000);
        repeat (2) u_dbt_cpu_bfm.bus(16'h0300, 1'b1, COF_COND, 16'h0);
        u_dbt_cpu_bfm.bus(16'h0500, 1'b1, COF_COND, 16'h0000);
        rq(R_CTRL, 8'h00, 1'b1, 1'b0);
        rd(R_STAT, 8'h81);
        repeat (FIFO_DEPTH - 1 - 1) rq(R_FIFO_L, 8'h00, 1'b0, 1'b1);
        rd(R_FIFO_H, 8'h05);
        rd(R_FIFO_L, 8'h00);
        // Event-only B: read data bytes stored, run ends when full
        rq(R_CMPB_H, 8'h06, 1'b1, 1'b0);
        rq(R_CMPB_L, 8'h00, 1'b1, 1'b0);
        rq(R_TRIG, 8'h05, 1'b1, 1'b0);
        rq(R_CTRL, 8'h80, 1'b1, 1'b0);
        u_dbt_cpu_bfm.bus(16'h0600, 1'b0, COF_NONE, 16'h0000);
        rq(R_FIFO_L, 8'h00, 1'b0, 1'b1);
        rd(R_STAT, 8'h60);
        repeat (8) u_dbt_cpu_bfm.bus(16'h0600, 1'b0, COF_NONE, 16'h0);
        rd(R_STAT, 8'h48);
        repeat (8) rd(R_FIFO_L, 8'hA5);
        finish_test();
    end
    // Run is about a hundred cycles; far beyond that is a hang
    initial begin
        #(25 * 5000);
        error_cnt++;
        finish_test();
    end
endmodule
`default_nettype wire

// file: verilog/dbt_comp.sv
// One qualified 16-bit comparator with equality and magnitude outputs
`timescale 1ns/100ps
`default_nettype none
module dbt_comp (
    input  wire logic [15:0] ref_val,
    input  wire logic [15:0] value,
    input  wire logic        valid,
    input  wire logic        suppress,
    input  wire logic        rw_en,
    input  wire logic        rw_val,
    input  wire logic        cpu_rw,
    output logic             eq,
    output logic             lt,
    output logic             gt
);
    logic qual;

    // Debugger accesses and R/W mismatches mask every output
    always_comb begin
        qual = valid && !suppress && (!rw_en || (cpu_rw == rw_val));
        eq   = qual && (value == ref_val);
        lt   = qual && (value < ref_val);
        gt   = qual && (value > ref_val);
    end
endmodule
`default_nettype wire

// file: verilog/dbt_pkg.sv
// Constants, carriers and state types of the debug breakpoint/trace block
package dbt_pkg;
    // Register port indices (one byte each)
    localparam logic [3:0] R_BKPT_H  = 4'h0;
    localparam logic [3:0] R_BKPT_L  = 4'h1;
    localparam logic [3:0] R_BDC_CTL = 4'h2;
    localparam logic [3:0] R_CMPA_H  = 4'h3;
    localparam logic [3:0] R_CMPA_L  = 4'h4;
    localparam logic [3:0] R_CMPB_H  = 4'h5;
    localparam logic [3:0] R_CMPB_L  = 4'h6;
    localparam logic [3:0] R_FIFO_H  = 4'h7;
    localparam logic [3:0] R_FIFO_L  = 4'h8;
    localparam logic [3:0] R_CTRL    = 4'h9;
    localparam logic [3:0] R_TRIG    = 4'hA;
    localparam logic [3:0] R_STAT    = 4'hB;
    // Background controller control bits
    localparam int BKPT_EN_BIT = 7;
    localparam int FTSEL_BIT   = 6;
    // Debug control bits
    localparam int ARM_BIT   = 7;
    localparam int BRKEN_BIT = 6;
    localparam int TAG_BIT   = 5;
    localparam int COMP_A_RW_QUALIFY_ENABLE_BIT = 3;
    localparam int RWA_BIT   = 2;
    localparam int RWBEN_BIT = 1;
    localparam int RWB_BIT   = 0;
    // Trigger control bits; mode in the low nibble
    localparam int TRGSEL_BIT = 7;
    localparam int BEGIN_BIT  = 6;
    // Status bits; valid count in the low nibble
    localparam int AFLAG_BIT = 7;
    localparam int BFLAG_BIT = 6;
    localparam int ARMED_BIT = 5;
    // FIFO shape and counts
    localparam int         FIFO_DEPTH = 8;
    localparam logic [3:0] CNT_FULL   = 4'h8;
    localparam logic [3:0] CNT_ONE    = 4'h1;
    localparam logic [1:0] COF_SKIP   = 2'h2;
    localparam logic [1:0] SKIP_ONE   = 2'h1;

    typedef logic [FIFO_DEPTH-1:0][15:0] dbt_fifo_t;

    typedef enum logic [3:0] {
        TM_A_ONLY, TM_A_OR_B, TM_A_THEN_B, TM_A_AND_BD, TM_A_NOT_BD,
        TM_EV_B, TM_A_THEN_EV_B, TM_INSIDE, TM_OUTSIDE
    } dbt_mode_e;

    typedef enum logic [2:0] {
        COF_NONE, COF_COND, COF_ALWAYS, COF_NEVER,
        COF_INDIRECT, COF_IRQ, COF_RET_INT, COF_RET_SUB
    } dbt_cof_e;

    typedef enum logic [1:0] {RS_IDLE, RS_WAIT, RS_CAPT} dbt_run_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  rdata;
        logic [7:0]  wdata;
        logic        rw;
        logic        op_fetch;
        logic        bdc_access;
    } dbt_cpu_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } dbt_exec_s;

    typedef struct packed {
        dbt_cof_e    kind;
        logic [15:0] src;
        logic [15:0] dst;
    } dbt_cof_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dbt_reg_req_s;

    typedef struct packed {
        logic [15:0] bdc_breakpoint_match;
        logic        breakpoint_enable_bit;
        logic        force_tag_select;
        logic [15:0] cmp_a_ref;
        logic [15:0] cmp_b_ref;
        logic [7:0]  ctrl;
        logic [7:0]  trig;
        dbt_run_e    run;
        logic        comp_a_match_flag;
        logic        comp_b_match_flag;
        logic        seen_a;
        logic [3:0]  fifo_valid_count;
        logic [1:0]  skip_left;
        dbt_fifo_t   fifo;
        logic [15:0] last_fetch;
        logic [7:0]  rdata;
        logic        force_brk;
        logic        tag_brk;
    } dbt_state_s;
endpackage

// file: verilog/dbt_top.sv
// Debug breakpoint, trigger and trace FIFO logic beside the CPU
//
// Behaviour
// R1: Compare CPU address to stored 16-bit match value every bus cycle.
// R2: Forced mode: any access to match address requests background entry.
// R3: Tagged mode: opcode fetched from match address is marked for the CPU.
// R4: Enable bit resets to 0; while 0 no controller breakpoint is requested.
// R5: Select bit 1 chooses forced, 0 chooses tagged breakpoints.
// R6: Eight-entry capture FIFO fed under control of the trigger logic.
// R7: Two 16-bit comparators, each with its own optional R/W qualification.
// R8: Opcode tracking: match counts only when the opcode actually executes.
// R9: Comparators also give less-than and greater-than for range modes.
// R10: Comparators are suppressed during every debugger bus access.
// R11: A compares address; B compares address or 8-bit data by mode.
// R12: Data compare uses write bus if A qualifies on write, else read bus.
// R13: A qualified match breaks, stores data, begins or ends tracing.
// R14: Count reports valid words; early disarm shifts contents by one.
// R15: Address modes: high then low byte; low byte read shifts FIFO.
// R16: Event modes store 8-bit data; low byte read alone shifts FIFO.
// R17: Trigger change of flow and two cycles after it are not stored.
// R18: End trace stores a change-of-flow trigger as the last entry.
// R19: Disarmed, each low byte read pushes last fetched opcode address.
// R20: Profiling host discards the first eight values read.
// R21: Taken conditional branch stores its own address; always/never nothing.
// R22: Indirect jumps, interrupts and returns store the destination.
// R23: Writing arm set arms the run and clears match flags and count.
// R24: Begin trace ends when FIFO full; end trace ends at trigger.
// R25: Four-bit count 0 to 8, saturates at 8, drops per shifting read; a read that also pushes, as every disarmed read does, leaves it unchanged.
`timescale 1ns/100ps
`default_nettype none
module dbt_top (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire dbt_pkg::dbt_cpu_s     cpu,
    input  wire dbt_pkg::dbt_exec_s    exec_op,
    input  wire dbt_pkg::dbt_cof_s     cof,
    input  wire dbt_pkg::dbt_reg_req_s reg_req,
    output logic [7:0]                 reg_rdata,
    output logic                       force_break,
    output logic                       tag_break,
    output logic                       armed_flag
);
    import dbt_pkg::*;

    dbt_state_s  q;
    dbt_state_s  d;
    dbt_mode_e   mode;
    logic [15:0] cmp_addr;
    logic        cmp_valid;
    logic [7:0]  bus_data;
    logic        a_eq, a_lt, a_gt;
    logic        b_eq, b_lt, b_gt;
    logic        bd_eq;
    logic        trig, brk_trig, ev_mode, full_mode, begin_type;
    logic        bdc_hit, cof_ok, push, pop;
    logic [15:0] push_val, cof_val;
    logic        wr_ctrl, rd_low;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Shift toward the read head, new word enters at the tail
    function automatic dbt_fifo_t fifo_shift(input dbt_fifo_t f,
                                             input logic [15:0] v);
        dbt_fifo_t r;
        r = f;
        for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
            r[i] = f[i+1];
        end
        r[FIFO_DEPTH-1] = v;                                    // [R6]
        return r;
    endfunction

    // Whether a change of flow leaves an address in the FIFO
    function automatic logic cof_stores(input dbt_cof_e k);
        return (k == COF_COND) || (k == COF_INDIRECT) || (k == COF_IRQ)
            || (k == COF_RET_INT) || (k == COF_RET_SUB);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Comparators

    // Opcode tracking swaps the fetch address for the executed one
    always_comb begin
        mode      = dbt_mode_e'(q.trig[3:0]);
        cmp_addr  = q.trig[TRGSEL_BIT] ? exec_op.addr : cpu.addr; // [R8]
        cmp_valid = q.trig[TRGSEL_BIT] ? exec_op.valid : 1'b1;    // [R8]
        // Write bus only when A is qualified on write cycles
        bus_data  = (q.ctrl[COMP_A_RW_QUALIFY_ENABLE_BIT] && !q.ctrl[RWA_BIT])
                  ? cpu.wdata : cpu.rdata;                         // [R12]
    end

    // A always watches the address
    dbt_comp u_cmp_a (                                             // [R11]
        .ref_val  (q.cmp_a_ref),
        .value    (cmp_addr),
        .valid    (cmp_valid),
        .suppress (cpu.bdc_access),                                // [R10]
        .rw_en    (q.ctrl[COMP_A_RW_QUALIFY_ENABLE_BIT]),                             // [R7]
        .rw_val   (q.ctrl[RWA_BIT]),
        .cpu_rw   (cpu.rw),
        .eq       (a_eq),
        .lt       (a_lt),
        .gt       (a_gt)
    );

    // B on the address for address modes
    dbt_comp u_cmp_b (
        .ref_val  (q.cmp_b_ref),
        .value    (cmp_addr),
        .valid    (cmp_valid),
        .suppress (cpu.bdc_access),                                // [R10]
        .rw_en    (q.ctrl[RWBEN_BIT]),                             // [R7]
        .rw_val   (q.ctrl[RWB_BIT]),
        .cpu_rw   (cpu.rw),
        .eq       (b_eq),
        .lt       (b_lt),
        .gt       (b_gt)
    );

    // B low byte on data; its high half is forced equal, hence unused
    dbt_comp u_cmp_bd (                                            // [R11]
        .ref_val  (q.cmp_b_ref),
        .value    ({q.cmp_b_ref[15:8], bus_data}),
        .valid    (1'b1),
        .suppress (cpu.bdc_access),                                // [R10]
        .rw_en    (q.ctrl[COMP_A_RW_QUALIFY_ENABLE_BIT]),
        .rw_val   (q.ctrl[RWA_BIT]),
        .cpu_rw   (cpu.rw),
        .eq       (bd_eq),
        .lt       (),
        .gt       ()
    );

    ////////////////////////////////////////////////////////////////////
    // Trigger decode

    always_comb begin
        ev_mode   = (mode == TM_EV_B) || (mode == TM_A_THEN_EV_B);
        full_mode = (mode == TM_A_AND_BD) || (mode == TM_A_NOT_BD);
        // Event-only runs are always begin type
        begin_type = ev_mode || q.trig[BEGIN_BIT];
        case (mode)
            TM_A_ONLY:      trig = a_eq;
            TM_A_OR_B:      trig = a_eq || b_eq;
            TM_A_THEN_B:    trig = q.seen_a && b_eq;
            TM_A_AND_BD:    trig = a_eq && bd_eq;
            TM_A_NOT_BD:    trig = a_eq && !bd_eq;
            TM_EV_B:        trig = b_eq;
            TM_A_THEN_EV_B: trig = q.seen_a && b_eq;
            TM_INSIDE:      trig = (a_eq || a_gt) && (b_eq || b_lt); // [R9]
            TM_OUTSIDE:     trig = a_lt || b_gt;                     // [R9]
            default:        trig = 1'b0;
        endcase
        // A tag request in full modes ignores the data half
        brk_trig = (full_mode && q.ctrl[TAG_BIT]) ? a_eq : trig;
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d        = q;
        d.rdata  = 8'h00;
        push     = 1'b0;
        pop      = 1'b0;
        push_val = 16'h0000;
        wr_ctrl  = reg_req.wr && (reg_req.addr == R_CTRL);
        rd_low   = reg_req.rd && (reg_req.addr == R_FIFO_L);
        // Conditional branches keep the source, the rest the target
        cof_val  = (cof.kind == COF_COND) ? cof.src : cof.dst;   // [R21][R22]
        cof_ok   = cof_stores(cof.kind);                         // [R21][R22]

        // Background controller breakpoint, gated by its enable
        bdc_hit = q.breakpoint_enable_bit
               && (cpu.addr == q.bdc_breakpoint_match);          // [R1][R4]
        d.force_brk = bdc_hit && q.force_tag_select;             // [R2][R5]
        d.tag_brk   = bdc_hit && !q.force_tag_select
                   && cpu.op_fetch;                              // [R3][R5]
        // Debug module breakpoint while a run is armed
        if (q.run != RS_IDLE && q.ctrl[BRKEN_BIT] && brk_trig) begin
            if (q.ctrl[TAG_BIT]) begin
                d.tag_brk = 1'b1;                                // [R13]
            end else begin
                d.force_brk = 1'b1;                              // [R13]
            end
        end

        // Match flags and A-then-B memory while armed
        if (q.run != RS_IDLE) begin
            if (a_eq) begin
                d.comp_a_match_flag = 1'b1;
                d.seen_a = 1'b1;
            end
            if (full_mode ? bd_eq : b_eq) begin
                d.comp_b_match_flag = 1'b1;
            end
        end

        // Run sequencing and what gets captured
        case (q.run)
            RS_WAIT: begin
                if (trig) begin
                    d.run = RS_CAPT;                             // [R13]
                    d.skip_left = COF_SKIP;                      // [R17]
                end
            end
            RS_CAPT: begin
                if (ev_mode) begin
                    if (trig) begin
                        push = 1'b1;                             // [R13][R16]
                        push_val = {8'h00, bus_data};            // [R16]
                    end
                end else if (!begin_type && trig) begin
                    // Trigger that is itself a change of flow goes last
                    push = cof_ok;                               // [R18]
                    push_val = cof_val;
                    d.run = RS_IDLE;                             // [R24]
                end else if (q.skip_left != 2'h0) begin
                    d.skip_left = q.skip_left - SKIP_ONE;        // [R17]
                end else begin
                    push = cof_ok;
                    push_val = cof_val;
                end
            end
            default: begin
                // Disarmed: each low byte read samples the fetch address
                if (rd_low) begin
                    push = 1'b1;                                 // [R19]
                    push_val = q.last_fetch;                     // [R19]
                end
            end
        endcase

        // Low byte read shifts the FIFO toward the port
        pop = rd_low;                                            // [R15][R16]
        if (push || pop) begin
            d.fifo = fifo_shift(q.fifo, push ? push_val : 16'h0000);
        end
        if (push && !pop && q.fifo_valid_count != CNT_FULL) begin
            d.fifo_valid_count = q.fifo_valid_count + CNT_ONE;   // [R25]
        end else if (pop && !push && q.fifo_valid_count != 4'h0) begin
            d.fifo_valid_count = q.fifo_valid_count - CNT_ONE;   // [R25]
        end
        // Begin-type runs stop once the last free slot fills
        if (q.run != RS_IDLE && begin_type && push && !pop
            && q.fifo_valid_count == CNT_FULL - CNT_ONE) begin
            d.run = RS_IDLE;                                     // [R24]
        end

        if (cpu.op_fetch) begin
            d.last_fetch = cpu.addr;
        end

        // Register writes; arming overrides any capture this cycle
        if (reg_req.wr) begin
            if (reg_req.addr == R_BKPT_H) begin
                d.bdc_breakpoint_match[15:8] = reg_req.wdata;
            end else if (reg_req.addr == R_BKPT_L) begin
                d.bdc_breakpoint_match[7:0] = reg_req.wdata;
            end else if (reg_req.addr == R_BDC_CTL) begin
                d.breakpoint_enable_bit = reg_req.wdata[BKPT_EN_BIT];
                d.force_tag_select = reg_req.wdata[FTSEL_BIT];
            end else if (reg_req.addr == R_CMPA_H) begin
                d.cmp_a_ref[15:8] = reg_req.wdata;
            end else if (reg_req.addr == R_CMPA_L) begin
                d.cmp_a_ref[7:0] = reg_req.wdata;
            end else if (reg_req.addr == R_CMPB_H) begin
                d.cmp_b_ref[15:8] = reg_req.wdata;
            end else if (reg_req.addr == R_CMPB_L) begin
                d.cmp_b_ref[7:0] = reg_req.wdata;
            end else if (reg_req.addr == R_TRIG) begin
                d.trig = reg_req.wdata;
            end
        end
        if (wr_ctrl) begin
            d.ctrl = reg_req.wdata;
            if (reg_req.wdata[ARM_BIT]) begin
                // End trace and event runs record from arming; other begin runs wait for trigger
                d.run = begin_type && !ev_mode ? RS_WAIT : RS_CAPT;
                if (!ev_mode && !q.trig[BEGIN_BIT]) begin
                    d.run = RS_CAPT;
                end
                d.comp_a_match_flag = 1'b0;                      // [R23]
                d.comp_b_match_flag = 1'b0;                      // [R23]
                d.fifo_valid_count  = 4'h0;                      // [R23]
                d.seen_a    = 1'b0;
                d.skip_left = 2'h0;
            end else begin
                d.run = RS_IDLE;
                // Early stop leaves contents one slot further along
                if (q.run != RS_IDLE && q.fifo_valid_count != CNT_FULL) begin
                    d.fifo = fifo_shift(q.fifo, 16'h0000);       // [R14]
                end
            end
        end

        // Read data, one cycle after the strobe
        if (reg_req.rd) begin
            if (reg_req.addr == R_BKPT_H) begin
                d.rdata = q.bdc_breakpoint_match[15:8];
            end else if (reg_req.addr == R_BKPT_L) begin
                d.rdata = q.bdc_breakpoint_match[7:0];
            end else if (reg_req.addr == R_BDC_CTL) begin
                d.rdata[BKPT_EN_BIT] = q.breakpoint_enable_bit;
                d.rdata[FTSEL_BIT]   = q.force_tag_select;
            end else if (reg_req.addr == R_CMPA_H) begin
                d.rdata = q.cmp_a_ref[15:8];
            end else if (reg_req.addr == R_CMPA_L) begin
                d.rdata = q.cmp_a_ref[7:0];
            end else if (reg_req.addr == R_CMPB_H) begin
                d.rdata = q.cmp_b_ref[15:8];
            end else if (reg_req.addr == R_CMPB_L) begin
                d.rdata = q.cmp_b_ref[7:0];
            end else if (reg_req.addr == R_FIFO_H) begin
                d.rdata = q.fifo[0][15:8];                       // [R15]
            end else if (reg_req.addr == R_FIFO_L) begin
                d.rdata = q.fifo[0][7:0];                        // [R15]
            end else if (reg_req.addr == R_CTRL) begin
                d.rdata = q.ctrl;
            end else if (reg_req.addr == R_TRIG) begin
                d.rdata = q.trig;
            end else if (reg_req.addr == R_STAT) begin
                d.rdata[AFLAG_BIT] = q.comp_a_match_flag;
                d.rdata[BFLAG_BIT] = q.comp_b_match_flag;
                d.rdata[ARMED_BIT] = q.run != RS_IDLE;
                d.rdata[3:0] = q.fifo_valid_count;               // [R14]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;                                             // [R4]
        end else begin
            q <= d;
        end
    end

    assign reg_rdata   = q.rdata;
    assign force_break = q.force_brk;
    assign tag_break   = q.tag_brk;
    assign armed_flag  = q.run != RS_IDLE;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    bkpt_disabled_a: assert property (                           // [R4]
        (!q.breakpoint_enable_bit && q.run == RS_IDLE)
        |=> !force_break && !tag_break)
        else $error("Breakpoint raised while disabled");
    force_select_a: assert property (                            // [R2]
        (bdc_hit && q.force_tag_select) |=> force_break)
        else $error("Forced breakpoint not raised");
    tag_select_a: assert property (                              // [R3]
        (bdc_hit && !q.force_tag_select && cpu.op_fetch) |=> tag_break)
        else $error("Tagged breakpoint not raised");
    arm_clears_a: assert property (                              // [R23]
        (wr_ctrl && reg_req.wdata[ARM_BIT]) |=> armed_flag
        && q.fifo_valid_count == 4'h0 && !q.comp_a_match_flag
        && !q.comp_b_match_flag)
        else $error("Arm did not clear status");
    count_range_a: assert property (                             // [R25]
        q.fifo_valid_count <= CNT_FULL)
        else $error("Valid count above full");
    full_stop_a: assert property (                               // [R24]
        (armed_flag && begin_type && !$past(wr_ctrl))
        |-> q.fifo_valid_count != CNT_FULL)
        else $error("Begin run still armed when full");
    debug_quiet_a: assert property (                             // [R10]
        cpu.bdc_access |-> !a_eq && !b_eq && !bd_eq)
        else $error("Comparator matched on debugger access");
    pop_count_a: assert property (                               // [R15]
        (rd_low && !push && !wr_ctrl && q.fifo_valid_count != 4'h0)
        |=> q.fifo_valid_count == $past(q.fifo_valid_count) - CNT_ONE)
        else $error("Low byte read did not drop count");
    skip_window_a: assert property (                             // [R17]
        (q.run == RS_WAIT && trig && !wr_ctrl)
        |=> q.skip_left == COF_SKIP && !push ##1 !push)
        else $error("Change of flow stored inside skip window");
endmodule
`default_nettype wire
